/* rtl/lsc_pkg.sv */
/*
  Package for the per-channel signal-lost status combiner: register map over
  Avalon-MM, field positions, reset values and the condition carrier struct.
  Assumes a 32-bit Avalon-MM master with word addressing by byte address.
*/
package lsc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] lsc_addr_enable = 4'h0;
  localparam logic [3:0] lsc_addr_live = 4'h4;
  localparam logic [3:0] lsc_addr_irq_status = 4'h8;
  localparam logic [3:0] lsc_addr_irq_mask = 4'hC;
  localparam int lsc_addr_width = 4;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  // Enable register: channel A in bits 5:0, channel B in bits 13:8.
  // Bit order within a channel follows lsc_cond_type.
  localparam int lsc_cond_width = 6;
  localparam int lsc_chan_b_lsb = 8;
  localparam int lsc_en_master = 0;
  // Live register: per channel bits 6:0 = cond bits then combined output.
  localparam int lsc_live_width = 7;
  localparam int lsc_live_out = 6;
  // Interrupt status: bit 0 channel A output rose, bit 1 channel B.
  localparam int lsc_irq_width = 2;
  localparam int lsc_irq_chan_a = 0;
  localparam int lsc_irq_chan_b = 1;

  // ----------------------------------------------------------------------
  // Reset values: everything off
  // ----------------------------------------------------------------------
  localparam logic [lsc_cond_width-1:0] lsc_en_reset = 6'h00;
  localparam logic [lsc_irq_width-1:0] lsc_mask_reset = 2'h0;
  localparam logic [31:0] lsc_read_unmapped = 32'h0000_0000;

  // Per-channel condition bundle, already in "bad is high" polarity.
  typedef struct packed {
    logic azero_not_done;
    logic gain_unlocked;
    logic decode_error;
    logic pll_unlocked;
    logic sync_lost;
    logic swing_low;
  } lsc_cond_type;

endpackage

/* rtl/lsc_sync.sv */
/*
  Two flip-flop level synchroniser, WIDTH bits wide.
  Assumes each bit is a slow level; no multi-bit coherence is promised.
*/
`timescale 1ns/1ps
module lsc_sync #(
  parameter int width = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);

  logic [width-1:0] stage_one;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // First stage feeds only the second stage to bound metastability
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

/* rtl/lsc_combiner.sv */
/*
  Signal-lost status combiner for two channels. Merges detector and link
  health conditions per channel into one high-true status output, gated by
  software enables, and shows all of it over Avalon-MM with an interrupt.
  Assumes condition inputs are asynchronous levels from analog or other
  clock domains; they are synchronised here before use.
*/
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Channel output high when its low or high speed detector sees low swing.
// - Master output enable clears at reset; output stays low until set.
// - Every condition and combined output is readable over the register bus.
// - Enabled loss of channel sync is ORed into the channel output.
// - Enabled loss of PLL lock, either side, is ORed into output.
// - Enabled decode error, invalid code or disparity, is ORed into output.
// - Enabled inverted adaptive gain locked flag is ORed into output.
// - Enabled inverted auto-zero calibration done flag is ORed into output.
module lsc_combiner (
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [lsc_pkg::lsc_addr_width-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // Channel A raw conditions
  input wire logic chan_a_low_speed_rx_input,
  input wire logic chan_a_high_speed_rx_input,
  input wire logic chan_a_sync_lost,
  input wire logic chan_a_ls_pll_unlocked,
  input wire logic chan_a_hs_pll_unlocked,
  input wire logic chan_a_invalid_code,
  input wire logic chan_a_disparity_error,
  input wire logic chan_a_gain_adapt_locked_flag,
  input wire logic chan_a_autozero_cal_done_flag,
  // Channel B raw conditions
  input wire logic chan_b_low_speed_rx_input,
  input wire logic chan_b_high_speed_rx_input,
  input wire logic chan_b_sync_lost,
  input wire logic chan_b_ls_pll_unlocked,
  input wire logic chan_b_hs_pll_unlocked,
  input wire logic chan_b_invalid_code,
  input wire logic chan_b_disparity_error,
  input wire logic chan_b_gain_adapt_locked_flag,
  input wire logic chan_b_autozero_cal_done_flag,
  // Status outputs
  output logic chan_a_signal_lost_out,
  output logic chan_b_signal_lost_out
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Masked OR of one channel's conditions
  function automatic logic lsc_combine(input lsc_pkg::lsc_cond_type cond,
                                       input logic [lsc_pkg::lsc_cond_width-1:0] en);
    logic [lsc_pkg::lsc_cond_width-1:0] bits;
    bits = cond;
    return en[lsc_pkg::lsc_en_master] & (|(bits & en));
  endfunction

  // Byte-enable aware write merge
  function automatic logic [31:0] lsc_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Condition gathering
  // ----------------------------------------------------------------------
  lsc_pkg::lsc_cond_type raw_a;
  lsc_pkg::lsc_cond_type raw_b;
  lsc_pkg::lsc_cond_type cond_a;
  lsc_pkg::lsc_cond_type cond_b;
  logic [lsc_pkg::lsc_cond_width-1:0] sync_a;
  logic [lsc_pkg::lsc_cond_width-1:0] sync_b;

  assign raw_a.swing_low = chan_a_low_speed_rx_input | chan_a_high_speed_rx_input;
  assign raw_b.swing_low = chan_b_low_speed_rx_input | chan_b_high_speed_rx_input;
  assign raw_a.sync_lost = chan_a_sync_lost;
  assign raw_b.sync_lost = chan_b_sync_lost;
  assign raw_a.pll_unlocked = chan_a_ls_pll_unlocked | chan_a_hs_pll_unlocked;
  assign raw_b.pll_unlocked = chan_b_ls_pll_unlocked | chan_b_hs_pll_unlocked;
  assign raw_a.decode_error = chan_a_invalid_code | chan_a_disparity_error;
  assign raw_b.decode_error = chan_b_invalid_code | chan_b_disparity_error;
  assign raw_a.gain_unlocked = ~chan_a_gain_adapt_locked_flag;
  assign raw_b.gain_unlocked = ~chan_b_gain_adapt_locked_flag;
  assign raw_a.azero_not_done = ~chan_a_autozero_cal_done_flag;
  assign raw_b.azero_not_done = ~chan_b_autozero_cal_done_flag;

  // Merging before the synchroniser is safe: each term is only a level
  lsc_sync #(
    .width(lsc_pkg::lsc_cond_width)
  ) u_sync_a (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(raw_a),
    .sync_out(sync_a)
  );

  lsc_sync #(
    .width(lsc_pkg::lsc_cond_width)
  ) u_sync_b (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(raw_b),
    .sync_out(sync_b)
  );

  assign cond_a = sync_a;
  assign cond_b = sync_b;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [lsc_pkg::lsc_cond_width-1:0] enable_a;
  logic [lsc_pkg::lsc_cond_width-1:0] enable_b;
  logic [lsc_pkg::lsc_irq_width-1:0] irq_status;
  logic [lsc_pkg::lsc_irq_width-1:0] irq_mask;
  logic out_a_prev;
  logic out_b_prev;

  // Bus decode; one wait cycle so read data comes from a flop
  logic access;
  logic ack;
  logic wr_en;
  logic wr_live_ignored;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic [31:0] enable_word;
  logic [31:0] enable_merged;
  logic [31:0] wdata_be;
  logic [31:0] next_readdata;

  // Writes land in the acknowledge cycle, at the edge where waitrequest is low,
  // so a master that aborts during the wait cycle leaves no trace
  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack;
  assign wr_en = avs_write & ack & (avs_address == lsc_pkg::lsc_addr_enable);
  assign wr_live_ignored = avs_write & (avs_address == lsc_pkg::lsc_addr_live);
  assign wr_irq_status = avs_write & ack & (avs_address == lsc_pkg::lsc_addr_irq_status);
  assign wr_irq_mask = avs_write & ack & (avs_address == lsc_pkg::lsc_addr_irq_mask);
  assign wdata_be = lsc_merge(32'h0000_0000, avs_writedata, avs_byteenable);

  assign enable_word = {18'h00000, enable_b, 2'h0, enable_a};
  assign enable_merged = lsc_merge(enable_word, avs_writedata, avs_byteenable);

  // ----------------------------------------------------------------------
  // Combined outputs
  // ----------------------------------------------------------------------
  logic next_out_a;
  logic next_out_b;

  assign next_out_a = lsc_combine(cond_a, enable_a);
  assign next_out_b = lsc_combine(cond_b, enable_b);

  // Status pins are registered so they never glitch between conditions
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_a_signal_lost_out <= 1'b0;
      chan_b_signal_lost_out <= 1'b0;
      out_a_prev <= 1'b0;
      out_b_prev <= 1'b0;
    end else begin
      chan_a_signal_lost_out <= next_out_a;
      chan_b_signal_lost_out <= next_out_b;
      out_a_prev <= chan_a_signal_lost_out;
      out_b_prev <= chan_b_signal_lost_out;
    end
  end

  // ----------------------------------------------------------------------
  // Enable and mask registers
  // ----------------------------------------------------------------------
  // enables clear at reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_a <= lsc_pkg::lsc_en_reset;
      enable_b <= lsc_pkg::lsc_en_reset;
      irq_mask <= lsc_pkg::lsc_mask_reset;
    end else begin
      if (wr_en) begin
        enable_a <= enable_merged[lsc_pkg::lsc_cond_width-1:0];
        enable_b <= enable_merged[lsc_pkg::lsc_chan_b_lsb +: lsc_pkg::lsc_cond_width];
      end
      if (wr_irq_mask) begin
        irq_mask <= wdata_be[lsc_pkg::lsc_irq_width-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  logic [lsc_pkg::lsc_irq_width-1:0] rise;
  logic [lsc_pkg::lsc_irq_width-1:0] clr;
  logic [lsc_pkg::lsc_irq_width-1:0] next_irq_status;

  assign rise[lsc_pkg::lsc_irq_chan_a] = chan_a_signal_lost_out & ~out_a_prev;
  assign rise[lsc_pkg::lsc_irq_chan_b] = chan_b_signal_lost_out & ~out_b_prev;
  assign clr = wr_irq_status ? wdata_be[lsc_pkg::lsc_irq_width-1:0] : '0;
  // A rise in the clearing cycle survives: set has priority over clear
  assign next_irq_status = (irq_status & ~clr) | rise;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [31:0] live_word;
  logic [lsc_pkg::lsc_live_width-1:0] live_a;
  logic [lsc_pkg::lsc_live_width-1:0] live_b;

  assign live_a = {chan_a_signal_lost_out, sync_a};
  assign live_b = {chan_b_signal_lost_out, sync_b};
  assign live_word = {17'h00000, live_b, 1'b0, live_a};

  assign next_readdata =
    (avs_address == lsc_pkg::lsc_addr_enable) ? enable_word :
    (avs_address == lsc_pkg::lsc_addr_live) ? live_word :
    (avs_address == lsc_pkg::lsc_addr_irq_status) ? {30'h00000000, irq_status} :
    (avs_address == lsc_pkg::lsc_addr_irq_mask) ? {30'h00000000, irq_mask} :
    lsc_pkg::lsc_read_unmapped;

  // Ack toggles one cycle after a request; read data latched in same edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ack <= access & ~ack;
      if (avs_read & ~ack) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // Live register is read-only; writes to it are accepted and dropped
  logic unused_ok;
  assign unused_ok = wr_live_ignored;

endmodule

/* dv/lsc_combiner_assertions.sv */
/*
  Port checker for the signal-lost status combiner, bound to the design.
  Assumes one clock domain; enable state is rebuilt from acknowledged writes.
*/
`timescale 1ns/1ps
module lsc_combiner_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic chan_a_low_speed_rx_input,
  input wire logic chan_a_sync_lost,
  input wire logic chan_a_gain_adapt_locked_flag,
  input wire logic chan_a_autozero_cal_done_flag,
  input wire logic chan_b_high_speed_rx_input,
  input wire logic chan_b_hs_pll_unlocked,
  input wire logic chan_b_disparity_error,
  input wire logic chan_a_signal_lost_out,
  input wire logic chan_b_signal_lost_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [15:0] en;
  // Shadow enable: a write lands only at the edge that sees waitrequest low
  wire wr_en = avs_write && !avs_waitrequest && avs_address == lsc_pkg::lsc_addr_enable;
  wire [15:0] next_en = {avs_byteenable[1] ? avs_writedata[15:8] : en[15:8],
                         avs_byteenable[0] ? avs_writedata[7:0] : en[7:0]};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en <= 16'h0000;
    end else if (wr_en) begin
      en <= next_en;
    end
  end
  // Windows of four cycles cover the three-edge condition path with margin
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_swing_a_out: assert property ((chan_a_low_speed_rx_input && en[0])[*4] |=> chan_a_signal_lost_out)
    else $error("channel A swing loss not shown");
  a_swing_b_out: assert property ((chan_b_high_speed_rx_input && en[8])[*4] |=> chan_b_signal_lost_out)
    else $error("channel B swing loss not shown");
  a_off_stays_low: assert property ((!en[0])[*2] |=> !chan_a_signal_lost_out)
    else $error("channel A output high while disabled");
  a_sync_term_a: assert property ((chan_a_sync_lost && en[0] && en[1])[*4] |=> chan_a_signal_lost_out)
    else $error("channel A sync loss not ORed");
  a_pll_term_b: assert property ((chan_b_hs_pll_unlocked && en[8] && en[10])[*4] |=> chan_b_signal_lost_out)
    else $error("channel B pll loss not ORed");
  a_decode_term_b: assert property ((chan_b_disparity_error && en[8] && en[11])[*4] |=> chan_b_signal_lost_out)
    else $error("channel B decode error not ORed");
  a_gain_term_a: assert property ((!chan_a_gain_adapt_locked_flag && en[0] && en[4])[*4] |=> chan_a_signal_lost_out)
    else $error("channel A gain unlock not ORed");
  a_azero_term_a: assert property ((!chan_a_autozero_cal_done_flag && en[0] && en[5])[*4] |=> chan_a_signal_lost_out)
    else $error("channel A autozero not done not ORed");
  // Main scenarios reached
  cover property (en[0] && chan_a_signal_lost_out);
  cover property (en[11] && chan_b_signal_lost_out);
  cover property (avs_write && !avs_waitrequest);
endmodule
bind lsc_combiner lsc_combiner_assertions u_lsc_combiner_assertions (.*);

/* dv/test_lsc_combiner.sv */
/*
  Self-checking bench for the signal-lost status combiner.
  Assumes the design alone is the device; the bench is the bus master and the analog side.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module test_lsc_combiner;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [8:0] cond_a = 9'h000;
  logic [8:0] cond_b = 9'h000;
  logic out_a;
  logic out_b;
  logic [31:0] rd;
  int fail_count = 0;
  int checks_done = 0;
  // Enable bit serving each condition index, in bad-is-high order
  localparam int ebit [9] = '{0, 0, 1, 2, 2, 3, 3, 4, 5};
  lsc_combiner u_lsc_combiner (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .chan_a_low_speed_rx_input(cond_a[0]), .chan_a_high_speed_rx_input(cond_a[1]),
    .chan_a_sync_lost(cond_a[2]), .chan_a_ls_pll_unlocked(cond_a[3]),
    .chan_a_hs_pll_unlocked(cond_a[4]), .chan_a_invalid_code(cond_a[5]),
    .chan_a_disparity_error(cond_a[6]), .chan_a_gain_adapt_locked_flag(!cond_a[7]),
    .chan_a_autozero_cal_done_flag(!cond_a[8]),
    .chan_b_low_speed_rx_input(cond_b[0]), .chan_b_high_speed_rx_input(cond_b[1]),
    .chan_b_sync_lost(cond_b[2]), .chan_b_ls_pll_unlocked(cond_b[3]),
    .chan_b_hs_pll_unlocked(cond_b[4]), .chan_b_invalid_code(cond_b[5]),
    .chan_b_disparity_error(cond_b[6]), .chan_b_gain_adapt_locked_flag(!cond_b[7]),
    .chan_b_autozero_cal_done_flag(!cond_b[8]),
    .chan_a_signal_lost_out(out_a), .chan_b_signal_lost_out(out_b));
  // One bus access: request held until the edge that sees waitrequest low, answer taken
  // there, then released with one idle edge so the next call never re-raises in one step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    `CHK("wait states", 1, n)
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // Three-edge condition path plus margin
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask
  task automatic set_cond(input int ch, input int i, input logic v);
    if (ch == 1) cond_b[i] <= v;
    else cond_a[i] <= v;
  endtask
  task automatic t_reset();
    bus(1'b0, lsc_pkg::lsc_addr_enable, 32'h0, 4'hF);
    `CHK("enable reset", 32'h0000_0000, rd)
    bus(1'b0, lsc_pkg::lsc_addr_irq_mask, 32'h0, 4'hF);
    `CHK("mask reset", 32'h0000_0000, rd)
    cond_a[0] <= 1'b1;
    settle();
    `CHK("out_a disabled", 1'b0, out_a)
    `CHK("irq reset", 1'b0, irq)
    cond_a[0] <= 1'b0;
    settle();
  endtask
  // Every condition on both channels: gated by its own bit, other channel untouched
  task automatic t_terms();
    int sh;
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 9; i++) begin
        sh = ch * 8;
        bus(1'b1, lsc_pkg::lsc_addr_enable, 32'h1 << sh, 4'hF);
        set_cond(ch, i, 1'b1);
        settle();
        `CHK("out masked", 1'(i < 2), ch ? out_b : out_a)
        bus(1'b1, lsc_pkg::lsc_addr_enable, (32'h1 | (32'h1 << ebit[i])) << sh, 4'hF);
        settle();
        `CHK("out enabled", 1'b1, ch ? out_b : out_a)
        `CHK("other channel", 1'b0, ch ? out_a : out_b)
        bus(1'b0, lsc_pkg::lsc_addr_live, 32'h0, 4'hF);
        `CHK("live", (32'h40 | (32'h1 << ebit[i])) << sh, rd)
        set_cond(ch, i, 1'b0);
        settle();
        `CHK("out cleared", 1'b0, ch ? out_b : out_a)
      end
    end
  endtask
  task automatic t_bytes();
    bus(1'b1, lsc_pkg::lsc_addr_enable, 32'h0000_3F3F, 4'h2);
    bus(1'b0, lsc_pkg::lsc_addr_enable, 32'h0, 4'hF);
    `CHK("byte merge", 32'h0000_3F00, rd)
    bus(1'b1, lsc_pkg::lsc_addr_live, 32'h0000_FFFF, 4'hF);
    bus(1'b0, lsc_pkg::lsc_addr_live, 32'h0, 4'hF);
    `CHK("live read only", 32'h0000_0000, rd)
    bus(1'b0, 4'h6, 32'h0, 4'hF);
    `CHK("unmapped", lsc_pkg::lsc_read_unmapped, rd)
  endtask
  // Raise both channels, mask one, clear sticky bits by writing ones
  task automatic t_irq();
    bus(1'b1, lsc_pkg::lsc_addr_irq_status, 32'h3, 4'hF);
    bus(1'b1, lsc_pkg::lsc_addr_irq_mask, 32'h1, 4'hF);
    bus(1'b1, lsc_pkg::lsc_addr_enable, 32'h0000_0101, 4'hF);
    cond_a[0] <= 1'b1;
    cond_b[1] <= 1'b1;
    settle();
    `CHK("irq raised", 1'b1, irq)
    bus(1'b0, lsc_pkg::lsc_addr_irq_status, 32'h0, 4'hF);
    `CHK("status both", 32'h0000_0003, rd)
    cond_a[0] <= 1'b0;
    cond_b[1] <= 1'b0;
    bus(1'b1, lsc_pkg::lsc_addr_irq_status, 32'h1, 4'hF);
    settle();
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, lsc_pkg::lsc_addr_irq_mask, 32'h2, 4'hF);
    settle();
    `CHK("irq unmasked", 1'b1, irq)
    bus(1'b1, lsc_pkg::lsc_addr_irq_status, 32'h2, 4'hF);
    settle();
    `CHK("irq cleared", 1'b0, irq)
  endtask
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_terms();
    t_bytes();
    t_irq();
    final_report();
  end
  // Watchdog well beyond the roughly five hundred cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
